//--- shared/cwg_sd_params.svh
/*
  register offsets, field positions, reset values and response codes of the
  shutdown and rising dead-band block.
  assumes: included by bare name after the package.
*/
`ifndef CWG_SD_PARAMS_SVH
`define CWG_SD_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_SHUTDOWN_CONTROL 8'h00
`define OFS_RISING_DEADBAND  8'h04
`define OFS_WAVE_CONFIG      8'h08
`define OFS_POLARITY         8'h0c
`define OFS_IRQ_STATUS       8'h10
`define OFS_IRQ_MASK         8'h14

// ==========================================================
// shutdown_control field positions
`define BIT_SHUTDOWN_EVENT   7
`define BIT_AUTO_RESTART     6
`define BIT_COMP2_SD         3
`define BIT_COMP1_SD         2
`define BIT_FAULT_SD         1

// ==========================================================
// synchronised input indices
`define IDX_PWM1             0
`define IDX_PWM2             1
`define IDX_COMP1            2
`define IDX_COMP2            3
`define IDX_FAULT            4

// ==========================================================
// source select and shutdown state codes
`define SEL_PWM2             2'h3
`define SEL_PWM1             2'h2
`define SEL_COMP1            2'h1
`define SEL_COMP2            2'h0
`define SD_DRIVE_HIGH        2'h3
`define SD_DRIVE_LOW         2'h2
`define SD_TRISTATE          2'h1
`define SD_INACTIVE          2'h0

// ==========================================================
// reset values and bus responses
`define RST_SHUTDOWN_CONTROL 8'h00
`define RST_DEADBAND         6'h00
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

//--- shared/cwg_sd_pkg.sv
/*
  types of the shutdown and rising dead-band block: the whole state record.
  assumes: nothing beyond a systemverilog compiler.
*/
package cwg_sd_pkg;

  // ==========================================================
  // complete state of the block
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_ok;
    logic [7:0]  awaddr;
    logic        w_ok;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    logic [4:0]  filt;
    logic        flag;
    logic        arsen;
    logic        c2en;
    logic        c1en;
    logic        flten;
    logic [5:0]  dbr;
    logic [1:0]  sel;
    logic [1:0]  sda;
    logic [1:0]  sdb;
    logic        pola;
    logic        polb;
    logic        irq_stat;
    logic        irq_mask;
    logic        irq;
    logic        in_prev;
    logic [5:0]  db_cnt;
    logic        a_raw;
    logic        out_a;
    logic        oe_a;
    logic        out_b;
    logic        oe_b;
  } cwg_state_s;

endpackage

//--- test/cwg_shutdown_deadband_tb.sv
/*
  self-checking bench: register access, source select, dead band, shutdown.
  assumes: design, package and parameter header compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cwg_sd_params.svh"

module cwg_shutdown_deadband_tb;
  import cwg_sd_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, trip = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  src_in = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, a, a_oe, b, b_oe, irq, fault, overlap;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          errors = 0, checks_done = 0, d0, db0, dn, dx;
  int          nv[3] = '{1, 5, 63};
  int          en_bit[3] = '{3, 2, 1};

  // ==========================================================
  // clock and instances
  always #5 aclk = ~aclk;

  cwg_shutdown_deadband cwg_shutdown_deadband_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm_unit1_output(src_in[2]), .pwm_unit2_output(src_in[3]),
    .comparator1_async_output(src_in[1]), .comparator2_async_output(src_in[0]),
    .fault_input(fault), .output_a(a), .output_a_oe(a_oe), .output_b(b), .output_b_oe(b_oe), .irq(irq));

  half_bridge_model half_bridge_model_i (
    .aclk(aclk), .gate_high(a), .gate_high_oe(a_oe), .gate_low(b), .gate_low_oe(b_oe),
    .trip(trip), .fault_input(fault), .overlap(overlap));

  // ==========================================================
  // compare, report and finish
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // axi4-lite write: address and data together, bready held until bvalid
  task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] resp);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check(bresp, resp, "bresp");
  endtask

  // axi4-lite read: rready held until rvalid
  task rd(input logic [7:0] ad, input logic [31:0] exp, input logic [1:0] resp, input string what);
    @(posedge aclk);
    araddr <= ad;
    {arvalid, rready} <= 2'b11;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    check(rdata, exp, what);
    check(rresp, resp, "rresp");
  endtask

  // edges from a pwm1 rise until output a rises, and until output b falls
  task measure(input int n, output int da, output int db);
    wr(`OFS_RISING_DEADBAND, n, `RESP_OKAY);
    repeat (10) @(posedge aclk);
    src_in[2] <= 1'b1;
    da = 0;
    db = 0;
    while (a !== 1'b1 && da < 200)
    begin
      @(posedge aclk);
      da++;
      if (b === 1'b1) db++;
    end
    src_in[2] <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  // expected {oe, level} for a shutdown state code, polarity 0
  function automatic logic [1:0] sd_exp(input int c);
    return (c == 1) ? 2'b00 : {1'b1, c == 3};
  endfunction

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`OFS_SHUTDOWN_CONTROL, 32'h0, `RESP_OKAY, "ctrl reset");
    rd(`OFS_RISING_DEADBAND, 32'h0, `RESP_OKAY, "dbr reset");
    wr(`OFS_RISING_DEADBAND, 32'hff, `RESP_OKAY);
    rd(`OFS_RISING_DEADBAND, 32'h3f, `RESP_OKAY, "dbr top bits");
    wr(8'h40, 32'h1, `RESP_SLVERR);
    rd(8'h40, 32'h0, `RESP_SLVERR, "unmapped");
    // each select code: chosen input alone high, then alone low
    for (int c = 0; c < 4; c++)
    begin
      wr(`OFS_WAVE_CONFIG, c, `RESP_OKAY);
      src_in <= 4'h1 << c;
      repeat (10) @(posedge aclk);
      check(b, 1'b0, "b chosen high");
      src_in <= ~(4'h1 << c);
      trip <= 1'b1;
      repeat (10) @(posedge aclk);
      check(b, 1'b1, "b chosen low");
    end
    rd(`OFS_SHUTDOWN_CONTROL, 32'h0, `RESP_OKAY, "sources disabled");
    src_in <= 4'h0;
    trip <= 1'b0;
    // rising dead band against the zero setting
    wr(`OFS_WAVE_CONFIG, 32'h2, `RESP_OKAY);
    measure(0, d0, db0);
    check(d0 <= db0 + 1, 1, "zero band");
    foreach (nv[k])
    begin
      measure(nv[k], dn, dx);
      check((dn - d0 == nv[k]) || (dn - d0 == nv[k] + 1), 1, "band");
    end
    wr(`OFS_RISING_DEADBAND, 32'h0, `RESP_OKAY);
    // each shutdown source: set, held without restart, cleared by software
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFS_SHUTDOWN_CONTROL, 1 << en_bit[i], `RESP_OKAY);
      if (i == 2) trip <= 1'b1;
      else src_in[i] <= 1'b1;
      repeat (10) @(posedge aclk);
      rd(`OFS_SHUTDOWN_CONTROL, 32'h80 | (1 << en_bit[i]), `RESP_OKAY, "flag set");
      src_in <= 4'h0;
      trip <= 1'b0;
      repeat (10) @(posedge aclk);
      rd(`OFS_SHUTDOWN_CONTROL, 32'h80 | (1 << en_bit[i]), `RESP_OKAY, "flag held");
      wr(`OFS_SHUTDOWN_CONTROL, 1 << en_bit[i], `RESP_OKAY);
      rd(`OFS_SHUTDOWN_CONTROL, 1 << en_bit[i], `RESP_OKAY, "flag cleared");
    end
    // interrupt: sticky status, mask, write-one clear
    rd(`OFS_IRQ_STATUS, 32'h1, `RESP_OKAY, "irq status");
    check(irq, 1'b0, "irq masked");
    wr(`OFS_IRQ_MASK, 32'h1, `RESP_OKAY);
    rd(`OFS_IRQ_MASK, 32'h1, `RESP_OKAY, "irq mask");
    repeat (2) @(posedge aclk);
    check(irq, 1'b1, "irq unmasked");
    wr(`OFS_IRQ_STATUS, 32'h1, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0, "irq cleared");
    rd(`OFS_IRQ_STATUS, 32'h0, `RESP_OKAY, "status cleared");
    // shutdown states under comparator 1 with auto restart
    wr(`OFS_SHUTDOWN_CONTROL, 32'h44, `RESP_OKAY);
    src_in[1] <= 1'b1;
    repeat (10) @(posedge aclk);
    check(irq, 1'b1, "irq event");
    for (int c = 0; c < 4; c++)
    begin
      wr(`OFS_WAVE_CONFIG, 2 | (c << 4) | ((3 - c) << 6), `RESP_OKAY);
      repeat (4) @(posedge aclk);
      check({a_oe, a_oe & a}, sd_exp(c), "a shutdown state");
      check({b_oe, b_oe & b}, sd_exp(3 - c), "b shutdown state");
    end
    src_in <= 4'h0;
    repeat (10) @(posedge aclk);
    rd(`OFS_SHUTDOWN_CONTROL, 32'h44, `RESP_OKAY, "auto restart");
    // both polarities inverted: idle input gives a high and b low
    wr(`OFS_POLARITY, 32'h3, `RESP_OKAY);
    rd(`OFS_POLARITY, 32'h3, `RESP_OKAY, "polarity");
    repeat (2) @(posedge aclk);
    check({a, b}, 2'b10, "inverted outputs");
    check(overlap, 1'b0, "overlap");
    conclude;
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (30000) @(posedge aclk);
    errors++;
    conclude;
  end
endmodule

`default_nettype wire

//--- test/half_bridge_model.sv
/*
  half-bridge gate driver model: feeds the fault line and watches for overlap.
  assumes: one clock shared with the block, trip driven by the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module half_bridge_model (
  input  wire logic aclk,
  input  wire logic gate_high,
  input  wire logic gate_high_oe,
  input  wire logic gate_low,
  input  wire logic gate_low_oe,
  input  wire logic trip,
  output var  logic fault_input,
  output var  logic overlap
);
  // ==========================================================
  // fault line from the power stage, high while a trip is commanded
  always_comb fault_input = trip;

  // latch any cycle with both switches driven on (shoot-through)
  logic seen_overlap = 1'b0;
  always @(posedge aclk)
    if (gate_high_oe && gate_low_oe && gate_high && gate_low)
      seen_overlap <= 1'b1;
  always_comb overlap = seen_overlap;
endmodule

`default_nettype wire

//--- verilog/cwg_shutdown_deadband.sv
/*
  complementary waveform core: source select, rising dead band, auto-shutdown
  with restart, interrupt, axi4-lite register slave.
  assumes: one 100 mhz clock, synchronous active-low reset, asynchronous inputs.
*/
// Local design decisions: the AXI4-Lite register port and the address map.
// Summary of operation
// - input_source_select picks pwm2 (11), pwm1 (10), comparator 1 (01) or comparator 2 (00).
// - while the shutdown flag is set each output follows its own two-bit shutdown state.
// - the shutdown event flag in bit 7 of shutdown_control is set on a shutdown and cleared by auto restart or software.
// - bit 6 enables automatic restart; when clear the flag is held until software clears it.
// - bit 2 makes a high comparator 1 output cause shutdown; clear means no effect.
// - bit 1 makes an asserted fault input cause shutdown; clear means no effect.
// - a nonzero rising count n delays the rising edge of output a by n counts.
// - a rising count of zero adds no delay to the rising edge.
// - bits 7 and 6 of the rising dead-band register read as zero.
`timescale 1ns/10ps
`default_nettype none
`include "cwg_sd_params.svh"

module cwg_shutdown_deadband
  import cwg_sd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pwm_unit1_output,
  input  wire logic        pwm_unit2_output,
  input  wire logic        comparator1_async_output,
  input  wire logic        comparator2_async_output,
  input  wire logic        fault_input,
  output var  logic        output_a,
  output var  logic        output_a_oe,
  output var  logic        output_b,
  output var  logic        output_b_oe,
  output var  logic        irq
);

  // ==========================================================
  // state and combinational helpers
  cwg_state_s state_reg;
  cwg_state_s state_next;
  logic [4:0] pins;
  logic       src_c;
  logic       in_c;
  logic       rise_c;
  logic       wr_c;
  logic       b_raw;
  logic [7:0] rd_byte;
  logic       rd_hit;
  integer     i;

  assign pins = {fault_input, comparator2_async_output, comparator1_async_output,
                 pwm_unit2_output, pwm_unit1_output};

  // ==========================================================
  // next-state logic
  always_comb
  begin
    state_next = state_reg;
    rd_byte    = 8'h00;
    rd_hit     = 1'b1;
    // three-stage pin synchronisers, accepted once stages two and three agree
    state_next.s1 = pins;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (i = 0; i < 5; i = i + 1)
    begin
      if (state_reg.s2[i] == state_reg.s3[i])
      begin
        state_next.filt[i] = state_reg.s3[i];
      end
    end
    // enabled shutdown sources
    src_c = (state_reg.c1en & state_reg.filt[`IDX_COMP1])
          | (state_reg.c2en & state_reg.filt[`IDX_COMP2])
          | (state_reg.flten & state_reg.filt[`IDX_FAULT]);
    // waveform source
    case (state_reg.sel)
      `SEL_PWM2:  in_c = state_reg.filt[`IDX_PWM2];
      `SEL_PWM1:  in_c = state_reg.filt[`IDX_PWM1];
      `SEL_COMP1: in_c = state_reg.filt[`IDX_COMP1];
      default:    in_c = state_reg.filt[`IDX_COMP2];
    endcase
    rise_c = in_c & ~state_reg.in_prev;
    state_next.in_prev = in_c;

    // write channel capture
    if (s_axi_awvalid && state_reg.awready)
    begin
      state_next.aw_ok  = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready)
    begin
      state_next.w_ok   = 1'b1;
      state_next.wdata  = s_axi_wdata[7:0];
      state_next.wstrb0 = s_axi_wstrb[0];
    end
    if (state_reg.bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
    end
    // register write once both address and data are held
    wr_c = state_reg.aw_ok & state_reg.w_ok & ~state_reg.bvalid;
    if (wr_c)
    begin
      state_next.aw_ok  = 1'b0;
      state_next.w_ok   = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = `RESP_OKAY;
      case (state_reg.awaddr)
        `OFS_SHUTDOWN_CONTROL:
          if (state_reg.wstrb0)
          begin
            state_next.flag  = state_reg.wdata[`BIT_SHUTDOWN_EVENT];
            state_next.arsen = state_reg.wdata[`BIT_AUTO_RESTART];
            state_next.c2en  = state_reg.wdata[`BIT_COMP2_SD];
            state_next.c1en  = state_reg.wdata[`BIT_COMP1_SD];
            state_next.flten = state_reg.wdata[`BIT_FAULT_SD];
          end
        `OFS_RISING_DEADBAND:
          if (state_reg.wstrb0)
          begin
            state_next.dbr = state_reg.wdata[5:0];
          end
        `OFS_WAVE_CONFIG:
          if (state_reg.wstrb0)
          begin
            state_next.sel = state_reg.wdata[1:0];
            state_next.sda = state_reg.wdata[5:4];
            state_next.sdb = state_reg.wdata[7:6];
          end
        `OFS_POLARITY:
          if (state_reg.wstrb0)
          begin
            state_next.pola = state_reg.wdata[0];
            state_next.polb = state_reg.wdata[1];
          end
        `OFS_IRQ_STATUS:
          if (state_reg.wstrb0 && state_reg.wdata[0])
          begin
            state_next.irq_stat = 1'b0;
          end
        `OFS_IRQ_MASK:
          if (state_reg.wstrb0)
          begin
            state_next.irq_mask = state_reg.wdata[0];
          end
        default: state_next.bresp = `RESP_SLVERR;
      endcase
    end

    // shutdown flag: hardware set beats software clear
    if (src_c)
    begin
      state_next.flag = 1'b1;
    end
    else if (state_reg.arsen)
    begin
      state_next.flag = 1'b0;
    end
    // sticky event bit, set wins over write-one-to-clear
    if (src_c && !state_reg.flag)
    begin
      state_next.irq_stat = 1'b1;
    end
    state_next.irq = state_next.irq_stat & state_next.irq_mask;

    // read channel
    case (s_axi_araddr)
      `OFS_SHUTDOWN_CONTROL: rd_byte = {state_reg.flag, state_reg.arsen, 2'h0, state_reg.c2en,
                                        state_reg.c1en, state_reg.flten, 1'b0};
      `OFS_RISING_DEADBAND:  rd_byte = {2'h0, state_reg.dbr};
      `OFS_WAVE_CONFIG:      rd_byte = {state_reg.sdb, state_reg.sda, 2'h0, state_reg.sel};
      `OFS_POLARITY:         rd_byte = {6'h00, state_reg.polb, state_reg.pola};
      `OFS_IRQ_STATUS:       rd_byte = {7'h00, state_reg.irq_stat};
      `OFS_IRQ_MASK:         rd_byte = {7'h00, state_reg.irq_mask};
      default:               rd_hit  = 1'b0;
    endcase
    if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arready)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = {24'h000000, rd_byte};
      state_next.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    state_next.awready = ~state_next.aw_ok & ~state_next.bvalid;
    state_next.wready  = ~state_next.w_ok & ~state_next.bvalid;
    state_next.arready = ~state_next.rvalid;

    // rising dead band on output a, falling edge passes at once
    if (!in_c)
    begin
      state_next.a_raw  = 1'b0;
      state_next.db_cnt = 6'h00;
    end
    else if (rise_c)
    begin
      if (state_reg.dbr == 6'h00)
      begin
        state_next.a_raw = 1'b1;
      end
      else
      begin
        state_next.a_raw  = 1'b0;
        state_next.db_cnt = state_reg.dbr;
      end
    end
    else if (state_reg.db_cnt != 6'h00)
    begin
      state_next.db_cnt = state_reg.db_cnt - 6'h01;
      if (state_reg.db_cnt == 6'h01)
      begin
        state_next.a_raw = 1'b1;
      end
    end
    b_raw = ~in_c;

    // output drive: normal complementary or per-output shutdown state
    state_next.oe_a  = 1'b1;
    state_next.oe_b  = 1'b1;
    state_next.out_a = state_next.a_raw ^ state_reg.pola;
    state_next.out_b = b_raw ^ state_reg.polb;
    if (state_next.flag)
    begin
      case (state_reg.sda)
        `SD_DRIVE_HIGH: state_next.out_a = 1'b1;
        `SD_DRIVE_LOW:  state_next.out_a = 1'b0;
        `SD_TRISTATE:   state_next.oe_a  = 1'b0;
        default:        state_next.out_a = state_reg.pola;
      endcase
      case (state_reg.sdb)
        `SD_DRIVE_HIGH: state_next.out_b = 1'b1;
        `SD_DRIVE_LOW:  state_next.out_b = 1'b0;
        `SD_TRISTATE:   state_next.oe_b  = 1'b0;
        default:        state_next.out_b = state_reg.polb;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready  = state_reg.wready;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;
  assign output_a      = state_reg.out_a;
  assign output_a_oe   = state_reg.oe_a;
  assign output_b      = state_reg.out_b;
  assign output_b_oe   = state_reg.oe_b;
  assign irq           = state_reg.irq;

  // ==========================================================
  // assertions and covers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SOURCE_SELECT: assert property (
    !state_reg.flag && $past(state_reg.sel) == `SEL_PWM2
    |-> state_reg.out_b == (~$past(state_reg.filt[`IDX_PWM2]) ^ $past(state_reg.polb)))
    else $error("output b does not follow pwm2 when selected");
  // the output flops take the shutdown state of the cycle before, so a fresh write lags by one edge
  AST_SD_TRISTATE: assert property (
    state_reg.flag && $past(state_reg.sda) == `SD_TRISTATE |-> !state_reg.oe_a)
    else $error("output a driven while shut down as tri-state");
  AST_SD_HIGH_B: assert property (
    state_reg.flag && $past(state_reg.sdb) == `SD_DRIVE_HIGH |-> state_reg.out_b && state_reg.oe_b)
    else $error("output b not high in drive-high shutdown");
  AST_FLAG_HELD: assert property (
    state_reg.flag && !state_reg.arsen && !wr_c |=> state_reg.flag)
    else $error("shutdown flag dropped without restart or write");
  AST_AUTO_RESTART: assert property (
    state_reg.flag && state_reg.arsen && !src_c |=> !state_reg.flag)
    else $error("auto restart did not clear the flag");
  AST_COMP1_SD: assert property (
    state_reg.c1en && state_reg.filt[`IDX_COMP1]
    |=> state_reg.flag && ($past(state_reg.sda) != `SD_TRISTATE || !state_reg.oe_a))
    else $error("comparator 1 did not shut down");
  AST_COMP2_SD: assert property (
    state_reg.c2en && state_reg.filt[`IDX_COMP2] |=> state_reg.flag)
    else $error("comparator 2 did not shut down");
  AST_FAULT_SD: assert property (
    state_reg.flten && state_reg.filt[`IDX_FAULT] |=> state_reg.flag)
    else $error("fault input did not shut down");
  AST_DB_LOAD: assert property (
    rise_c && state_reg.dbr != 6'h00 |=> state_reg.db_cnt == $past(state_reg.dbr) && !state_reg.a_raw)
    else $error("dead band not loaded on rising edge");
  AST_DB_END: assert property (
    state_reg.db_cnt == 6'h01 && in_c |=> state_reg.a_raw)
    else $error("output a not released at end of dead band");
  AST_DB_ZERO: assert property (
    rise_c && state_reg.dbr == 6'h00 |=> state_reg.a_raw)
    else $error("zero dead band delayed the rising edge");
  AST_DB_READ_ZERO: assert property (
    s_axi_arvalid && state_reg.arready && s_axi_araddr == `OFS_RISING_DEADBAND
    |=> state_reg.rdata[31:6] == 26'h0000000)
    else $error("upper dead-band bits read non-zero");

  COV_SHUTDOWN: cover property (!state_reg.flag ##1 state_reg.flag);
  COV_RESTART: cover property (state_reg.flag && state_reg.arsen ##1 !state_reg.flag);
  COV_DB_DONE: cover property (state_reg.db_cnt == 6'h01 ##1 state_reg.a_raw);
  COV_IRQ: cover property (state_reg.irq);

endmodule

`default_nettype wire
